// ### hdl/io_core_pkg.sv
package io_core_pkg;

	// Clock and timing figures
	localparam int CLK_HZ        = 50_000_000;
	localparam int ADC_RATE_HZ   = 10;
	localparam int SAMPLE_RATE_HZ = 1000;
	localparam int MS_PER_S      = 1000;
	localparam int ADC_TICK_CYC  = CLK_HZ / ADC_RATE_HZ;
	localparam int SMP_TICK_CYC  = CLK_HZ / SAMPLE_RATE_HZ;
	localparam int MS_TICK_CYC   = CLK_HZ / MS_PER_S;
	localparam int SYNC_SETTLE   = 3;

	// Register offsets (word addresses on the serial link)
	localparam logic [15:0] REG_RAW_BASE  = 16'h0000;
	localparam logic [15:0] REG_ENG_BASE  = 16'h0064;
	localparam logic [15:0] REG_CALH_BASE = 16'h0190;
	localparam logic [15:0] REG_CALL_BASE = 16'h0258;
	localparam logic [15:0] REG_FILTER    = 16'h04b0;
	localparam logic [15:0] REG_RANGE     = 16'h04b2;

	// Function and exception codes
	localparam logic [7:0] FC_READ_HOLD   = 8'h03;
	localparam logic [7:0] FC_READ_INPUT  = 8'h04;
	localparam logic [7:0] FC_WRITE_ONE   = 8'h06;
	localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
	localparam logic [7:0] EXC_BAD_FUNC   = 8'h01;
	localparam logic [7:0] EXC_BAD_ADDR   = 8'h02;

	// Limits and reset values
	localparam logic [15:0] FILT_MIN     = 16'h0001;
	localparam logic [15:0] FILT_MAX     = 16'h0010;
	localparam logic [4:0]  FILT_RESET   = 5'h06;
	localparam logic [15:0] RANGE_MAX    = 16'h0001;
	localparam logic        RANGE_RESET  = 1'b0;
	localparam logic [4:0]  DEB_MIN      = 5'h01;
	localparam logic [4:0]  DEB_MAX      = 5'h10;
	localparam logic [15:0] PULSE_MIN    = 16'h0032;
	localparam logic [7:0]  OFFS_MIN     = 8'h01;
	localparam logic [7:0]  OFFS_MAX     = 8'he0;
	localparam logic [7:0]  ADDR_MIN     = 8'h01;
	localparam logic [7:0]  ADDR_MAX     = 8'hf7;
	localparam logic [31:0] RAW_FULL     = 32'h0000_0fff;
	localparam logic [31:0] ENG_FULL     = 32'h0000_61a8;
	localparam logic [31:0] ENG_CAL_HI   = 32'h0000_4e20;
	localparam logic [31:0] ENG_4MA      = 32'h0000_0fa0;

	typedef enum logic [1:0] {
		TRIG_RISE  = 2'b00,
		TRIG_FALL  = 2'b01,
		TRIG_LEVEL = 2'b10
	} trig_mode_t;

	typedef enum logic [1:0] {
		RELAY_LEVEL  = 2'b00,
		RELAY_PULSE  = 2'b01,
		RELAY_FOLLOW = 2'b10
	} relay_mode_t;

	typedef enum logic [1:0] {
		ADDR_SETTLE = 2'b00,
		ADDR_HOLD   = 2'b01
	} addr_state_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  func;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic        exc;
		logic [7:0]  exc_code;
		logic [15:0] rdata;
	} reg_rsp_t;

	typedef struct packed {
		trig_mode_t  mode;
		logic        manual_clr;
		logic [4:0]  debounce;
	} switch_cfg_t;

	typedef struct packed {
		relay_mode_t mode;
		logic [15:0] width;
		logic [3:0]  follow_sel;
	} relay_cfg_t;

endpackage

// ### hdl/io_module_core.sv
`timescale 1ns/100ps
module io_module_core
	import io_core_pkg::*;
#(
	parameter int NUM_CUR       = 2,
	parameter int NUM_SW        = 2,
	parameter int NUM_RELAY     = 2,
	parameter int ADC_CYCLES    = io_core_pkg::ADC_TICK_CYC,
	parameter int SAMPLE_CYCLES = io_core_pkg::SMP_TICK_CYC,
	parameter int MS_CYCLES     = io_core_pkg::MS_TICK_CYC
) (
	input  wire logic                                   clk_i,
	input  wire logic                                   rstn_i,
	input  wire io_core_pkg::reg_req_t                  req_i,
	output io_core_pkg::reg_rsp_t                       rsp_o,
	output logic [NUM_CUR-1:0]                          adc_start_o,
	input  wire logic [NUM_CUR-1:0][11:0]               adc_data_i,
	input  wire logic [NUM_SW-1:0]                      switch_sense_input_i,
	input  wire io_core_pkg::switch_cfg_t [NUM_SW-1:0]  switch_cfg_i,
	input  wire logic [NUM_SW-1:0]                      count_clear_i,
	input  wire logic [NUM_SW-1:0]                      count_taken_i,
	output logic [NUM_SW-1:0][15:0]                     event_count_o,
	output logic [NUM_SW-1:0]                           switch_state_o,
	input  wire io_core_pkg::relay_cfg_t [NUM_RELAY-1:0] relay_cfg_i,
	input  wire logic [NUM_RELAY-1:0]                   relay_cmd_i,
	output logic [NUM_RELAY-1:0]                        relay_o,
	output logic [NUM_RELAY-1:0]                        relay_led_o,
	input  wire logic [4:0]                             dip_addr_i,
	input  wire logic [7:0]                             addr_offset_i,
	output logic [7:0]                                  bus_addr_o,
	output logic                                        bus_addr_valid_o
);

	import io_core_pkg::*;

	localparam int ADC_CW = $clog2(ADC_CYCLES + 1);
	localparam int SMP_CW = $clog2(SAMPLE_CYCLES + 1);
	localparam int MS_CW  = $clog2(MS_CYCLES + 1);

	typedef struct packed {
		logic [ADC_CW-1:0]                adc_cnt;
		logic [SMP_CW-1:0]                smp_cnt;
		logic [MS_CW-1:0]                 ms_cnt;
		logic [NUM_CUR-1:0][15:0][11:0]   hist;
		logic [NUM_CUR-1:0][11:0]         raw;
		logic [NUM_CUR-1:0][15:0]         eng;
		logic [NUM_CUR-1:0][15:0]         cal_hi;
		logic [NUM_CUR-1:0][15:0]         cal_lo;
		logic [4:0]                       filt;
		logic                             range_4ma;
		logic [NUM_SW-1:0]                sw_meta;
		logic [NUM_SW-1:0]                sw_sync;
		logic [NUM_SW-1:0]                sw_last;
		logic [NUM_SW-1:0][4:0]           sw_run;
		logic [NUM_SW-1:0]                sw_stable;
		logic [NUM_SW-1:0][15:0]          count;
		logic [NUM_RELAY-1:0]             relay;
		logic [NUM_RELAY-1:0]             cmd_last;
		logic [NUM_RELAY-1:0][15:0]       pulse_left;
		logic [4:0]                       dip_meta;
		logic [4:0]                       dip_sync;
		addr_state_t                      addr_state;
		logic [1:0]                       settle;
		logic [7:0]                       bus_addr;
		logic [NUM_CUR-1:0]               adc_start;
		reg_rsp_t                         rsp;
	} state_t;

	state_t q;
	state_t d;

	// Saturate a 16-bit value into [lo, hi]
	function automatic logic [15:0] clamp16(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// Mean of the newest n entries of one channel's history
	function automatic logic [11:0] average(input logic [15:0][11:0] h,
		input logic [4:0] n);
		logic [15:0] sum;
		sum = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			if (5'(i) < n) begin
				sum = sum + {4'h0, h[i]};
			end
		end
		return 12'(sum / {11'h000, n});
	endfunction

	// Raw count to microamps, with optional two-point correction
	function automatic logic [15:0] to_eng(input logic [11:0] raw,
		input logic [15:0] hi, input logic [15:0] lo, input logic r4);
		logic [31:0] e;
		logic [31:0] r;
		r = {20'h00000, raw};
		if (hi > lo) begin
			if (r > {16'h0000, lo}) begin
				e = ((r - {16'h0000, lo}) * ENG_CAL_HI) /
					({16'h0000, hi} - {16'h0000, lo});
			end else begin
				e = 32'h0000_0000;
			end
		end else begin
			e = (r * ENG_FULL) / RAW_FULL;
		end
		if (e > ENG_FULL) begin
			e = ENG_FULL;
		end
		if (r4 && (e < ENG_4MA)) begin
			e = 32'h0000_0000;
		end
		return e[15:0];
	endfunction

	// Next state of the whole block
	always_comb begin
		logic adc_tick;
		logic smp_tick;
		logic ms_tick;
		logic found;
		logic is_write;
		logic [4:0] deb;
		logic [4:0] run;
		logic ev;
		logic [3:0] sel;
		logic [15:0] width;
		logic [7:0] hw_addr;
		logic [8:0] sum_addr;
		adc_tick = 1'b0;
		smp_tick = 1'b0;
		ms_tick  = 1'b0;
		found    = 1'b0;
		is_write = 1'b0;
		deb      = 5'h00;
		run      = 5'h00;
		ev       = 1'b0;
		sel      = 4'h0;
		width    = 16'h0000;
		hw_addr  = 8'h00;
		sum_addr = 9'h000;
		d = q;
		d.rsp = '0;
		d.adc_start = '0;

		// Free-running ticks: conversion, switch sample, millisecond
		if (q.adc_cnt == ADC_CW'(ADC_CYCLES - 1)) begin
			d.adc_cnt = '0;
			adc_tick = 1'b1;
		end else begin
			d.adc_cnt = q.adc_cnt + ADC_CW'(1);
		end
		if (q.smp_cnt == SMP_CW'(SAMPLE_CYCLES - 1)) begin
			d.smp_cnt = '0;
			smp_tick = 1'b1;
		end else begin
			d.smp_cnt = q.smp_cnt + SMP_CW'(1);
		end
		if (q.ms_cnt == MS_CW'(MS_CYCLES - 1)) begin
			d.ms_cnt = '0;
			ms_tick = 1'b1;
		end else begin
			d.ms_cnt = q.ms_cnt + MS_CW'(1);
		end

		// Current inputs: take a 12-bit sample, average, scale
		for (int c = 0; c < NUM_CUR; c++) begin
			if (adc_tick) begin
				d.hist[c] = {q.hist[c][14:0], adc_data_i[c]};
				d.adc_start[c] = 1'b1;
			end
			d.raw[c] = average(q.hist[c], q.filt);
			d.eng[c] = to_eng(q.raw[c], q.cal_hi[c], q.cal_lo[c],
				q.range_4ma);
		end

		// Switch inputs: two-flop sync, then debounce on sample ticks
		d.sw_meta = switch_sense_input_i;
		d.sw_sync = q.sw_meta;
		for (int s = 0; s < NUM_SW; s++) begin
			ev = 1'b0;
			if (smp_tick) begin
				deb = 5'(clamp16({11'h000, switch_cfg_i[s].debounce},
					{11'h000, DEB_MIN}, {11'h000, DEB_MAX}));
				if (q.sw_sync[s] == q.sw_last[s]) begin
					run = (q.sw_run[s] == DEB_MAX) ? DEB_MAX
						: q.sw_run[s] + 5'h01;
				end else begin
					run = 5'h01;
				end
				d.sw_run[s] = run;
				d.sw_last[s] = q.sw_sync[s];
				if ((run >= deb) && (q.sw_sync[s] != q.sw_stable[s])) begin
					d.sw_stable[s] = q.sw_sync[s];
					case (switch_cfg_i[s].mode)
						TRIG_RISE: begin
							ev = q.sw_sync[s];
						end
						TRIG_FALL: begin
							ev = ~q.sw_sync[s];
						end
						TRIG_LEVEL: begin
							ev = 1'b1;
						end
						default: begin
							ev = 1'b0;
						end
					endcase
				end
			end
			// Clearing first so a same-cycle event still counts
			if (count_clear_i[s] ||
				(!switch_cfg_i[s].manual_clr && count_taken_i[s])) begin
				d.count[s] = 16'h0000;
			end
			if (ev) begin
				d.count[s] = d.count[s] + 16'h0001;
			end
		end

		// Relays: level, timed pulse or follow a debounced switch
		for (int r = 0; r < NUM_RELAY; r++) begin
			d.cmd_last[r] = relay_cmd_i[r];
			case (relay_cfg_i[r].mode)
				RELAY_LEVEL: begin
					d.relay[r] = relay_cmd_i[r];
					d.pulse_left[r] = 16'h0000;
				end
				RELAY_PULSE: begin
					width = (relay_cfg_i[r].width < PULSE_MIN) ? PULSE_MIN
						: relay_cfg_i[r].width;
					if (relay_cmd_i[r] && !q.cmd_last[r]) begin
						d.relay[r] = 1'b1;
						d.pulse_left[r] = width;
					end else if (ms_tick && q.relay[r]) begin
						d.pulse_left[r] = q.pulse_left[r] - 16'h0001;
						if (q.pulse_left[r] <= 16'h0001) begin
							d.relay[r] = 1'b0;
							d.pulse_left[r] = 16'h0000;
						end
					end
				end
				RELAY_FOLLOW: begin
					sel = relay_cfg_i[r].follow_sel;
					d.pulse_left[r] = 16'h0000;
					d.relay[r] = 1'b0;
					for (int s = 0; s < NUM_SW; s++) begin
						if (sel == 4'(s)) begin
							d.relay[r] = q.sw_stable[s];
						end
					end
				end
				default: begin
					d.relay[r] = 1'b0;
					d.pulse_left[r] = 16'h0000;
				end
			endcase
		end

		// Address: sync the switch bank, capture once after reset
		d.dip_meta = dip_addr_i;
		d.dip_sync = q.dip_meta;
		case (q.addr_state)
			ADDR_SETTLE: begin
				if (q.settle == 2'(SYNC_SETTLE - 1)) begin
					hw_addr = {3'h0, q.dip_sync[0], q.dip_sync[1],
						q.dip_sync[2], q.dip_sync[3], q.dip_sync[4]};
					sum_addr = {1'b0, hw_addr} + {1'b0, 8'(clamp16(
						{8'h00, addr_offset_i}, {8'h00, OFFS_MIN},
						{8'h00, OFFS_MAX}))};
					d.bus_addr = 8'(clamp16({7'h00, sum_addr},
						{8'h00, ADDR_MIN}, {8'h00, ADDR_MAX}));
					d.addr_state = ADDR_HOLD;
				end else begin
					d.settle = q.settle + 2'h1;
				end
			end
			ADDR_HOLD: begin
				d.addr_state = ADDR_HOLD;
			end
			default: begin
				d.addr_state = ADDR_SETTLE;
			end
		endcase

		// Register access: answer every request on the next edge
		if (req_i.valid) begin
			d.rsp.valid = 1'b1;
			is_write = (req_i.func == FC_WRITE_ONE) ||
				(req_i.func == FC_WRITE_MULTI);
			if (req_i.func == FC_READ_INPUT) begin
				for (int c = 0; c < NUM_CUR; c++) begin
					if (req_i.addr == REG_RAW_BASE + 16'(c)) begin
						d.rsp.rdata = {4'h0, q.raw[c]};
						found = 1'b1;
					end else if (req_i.addr == REG_ENG_BASE + 16'(c)) begin
						d.rsp.rdata = q.eng[c];
						found = 1'b1;
					end
				end
			end else if (req_i.func == FC_READ_HOLD) begin
				if (req_i.addr == REG_FILTER) begin
					d.rsp.rdata = {11'h000, q.filt};
					found = 1'b1;
				end else if (req_i.addr == REG_RANGE) begin
					d.rsp.rdata = {15'h0000, q.range_4ma};
					found = 1'b1;
				end
				for (int c = 0; c < NUM_CUR; c++) begin
					if (req_i.addr == REG_CALH_BASE + 16'(c)) begin
						d.rsp.rdata = q.cal_hi[c];
						found = 1'b1;
					end else if (req_i.addr == REG_CALL_BASE + 16'(c)) begin
						d.rsp.rdata = q.cal_lo[c];
						found = 1'b1;
					end
				end
			end else if (is_write) begin
				if (req_i.addr == REG_FILTER) begin
					d.filt = 5'(clamp16(req_i.wdata, FILT_MIN,
						FILT_MAX));
					found = 1'b1;
				end else if (req_i.addr == REG_RANGE) begin
					d.range_4ma = (req_i.wdata >= RANGE_MAX);
					found = 1'b1;
				end
				for (int c = 0; c < NUM_CUR; c++) begin
					if (req_i.addr == REG_CALH_BASE + 16'(c)) begin
						d.cal_hi[c] = req_i.wdata;
						found = 1'b1;
					end else if (req_i.addr == REG_CALL_BASE + 16'(c)) begin
						d.cal_lo[c] = req_i.wdata;
						found = 1'b1;
					end
				end
			end
			if (!(is_write || (req_i.func == FC_READ_HOLD) ||
				(req_i.func == FC_READ_INPUT))) begin
				d.rsp.exc = 1'b1;
				d.rsp.exc_code = EXC_BAD_FUNC;
			end else if (!found) begin
				d.rsp.exc = 1'b1;
				d.rsp.exc_code = EXC_BAD_ADDR;
			end
			if (is_write && found) begin
				d.rsp.rdata = req_i.wdata;                  // Echo the write
			end
		end
	end

	// All state in one register; reset gives defaults
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
			q.filt <= FILT_RESET;
			q.range_4ma <= RANGE_RESET;
			q.addr_state <= ADDR_SETTLE;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign rsp_o            = q.rsp;
	assign adc_start_o      = q.adc_start;
	assign event_count_o    = q.count;
	assign switch_state_o   = q.sw_stable;
	assign relay_o          = q.relay;
	assign relay_led_o      = q.relay;
	assign bus_addr_o       = q.bus_addr;
	assign bus_addr_valid_o = (q.addr_state == ADDR_HOLD);

endmodule // io_module_core

// ### sim/io_chk.sv
`timescale 1ns/100ps
module io_chk #(
	parameter int NUM_CUR   = 2,
	parameter int NUM_SW    = 2,
	parameter int NUM_RELAY = 2
) (
	input wire logic                                    clk_i,
	input wire logic                                    rstn_i,
	input wire io_core_pkg::reg_req_t                   req_i,
	input wire io_core_pkg::reg_rsp_t                   rsp_o,
	input wire logic [NUM_CUR-1:0]                      adc_start_o,
	input wire logic [NUM_SW-1:0][15:0]                 event_count_o,
	input wire io_core_pkg::relay_cfg_t [NUM_RELAY-1:0] relay_cfg_i,
	input wire logic [NUM_RELAY-1:0]                    relay_cmd_i,
	input wire logic [NUM_RELAY-1:0]                    relay_o,
	input wire logic [NUM_RELAY-1:0]                    relay_led_o,
	input wire logic [7:0]                              bus_addr_o,
	input wire logic                                    bus_addr_valid_o
);
	import io_core_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	logic bad_fn;
	// Function codes outside the four served ones
	assign bad_fn = !(req_i.func inside {FC_READ_HOLD, FC_READ_INPUT,
		FC_WRITE_ONE, FC_WRITE_MULTI});
	a_rsp_follows_req:
	assert property (req_i.valid |=> rsp_o.valid)
		else $error("no response after request");
	a_rsp_no_spurious:
	assert property (!req_i.valid |=> !rsp_o.valid)
		else $error("response without request");
	a_bad_func_code:
	assert property (req_i.valid && bad_fn |=>
		rsp_o.exc && rsp_o.exc_code == EXC_BAD_FUNC)
		else $error("unknown function not refused");
	a_led_tracks_relay:
	assert property (relay_led_o == relay_o)
		else $error("indicator differs from relay");
	a_addr_held:
	assert property (bus_addr_valid_o && $past(bus_addr_valid_o) |->
		$stable(bus_addr_o))
		else $error("bus address moved without restart");
	a_addr_in_range:
	assert property (bus_addr_valid_o |->
		bus_addr_o >= ADDR_MIN && bus_addr_o <= ADDR_MAX)
		else $error("bus address out of range");
	a_adc_tick_spacing:
	assert property (adc_start_o[0] |=> !adc_start_o[0] [*8])
		else $error("conversions too close together");
	a_count_steps_one:
	assert property ($changed(event_count_o[0]) |->
		event_count_o[0] == $past(event_count_o[0]) + 16'h0001 ||
		event_count_o[0] <= 16'h0001)
		else $error("event count jumped");
	a_pulse_starts:
	assert property (relay_cfg_i[0].mode == RELAY_PULSE &&
		$rose(relay_cmd_i[0]) |=> relay_o[0])
		else $error("pulse relay did not close");
	// Main scenarios reached
	c_exc: cover property (rsp_o.valid && rsp_o.exc);
	c_relay_off: cover property ($fell(relay_o[0]));
	c_addr: cover property ($rose(bus_addr_valid_o));
endmodule // io_chk

bind io_module_core io_chk #(
	.NUM_CUR(NUM_CUR),
	.NUM_SW(NUM_SW),
	.NUM_RELAY(NUM_RELAY)
) i_chk (
	.clk_i(clk_i),
	.rstn_i(rstn_i),
	.req_i(req_i),
	.rsp_o(rsp_o),
	.adc_start_o(adc_start_o),
	.event_count_o(event_count_o),
	.relay_cfg_i(relay_cfg_i),
	.relay_cmd_i(relay_cmd_i),
	.relay_o(relay_o),
	.relay_led_o(relay_led_o),
	.bus_addr_o(bus_addr_o),
	.bus_addr_valid_o(bus_addr_valid_o)
);

// ### sim/modbus_master_model.sv
`timescale 1ns/100ps
module modbus_master_model (
	input  wire logic           clk_i,
	output io_core_pkg::reg_req_t req_o
);
	import io_core_pkg::*;
	initial req_o = '0;
	// One word per call, raised off the falling edge and held over the
	// rising edge that takes it; stale fields are inverted afterwards so
	// an idle bus never looks like the last request
	task automatic xfer(input logic [7:0] f, input logic [15:0] a,
		input logic [15:0] d);
		@(negedge clk_i);
		req_o = '{1'b1, f, a, d};
		@(negedge clk_i);
		req_o = '{1'b0, ~f, ~a, ~d};
	endtask
endmodule // modbus_master_model

// ### sim/tb_io_module_core.sv
`timescale 1ns/100ps
module tb_io_module_core;
	import io_core_pkg::*;
	logic              clk_i, rstn_i, bvalid;
	reg_req_t          req;
	reg_rsp_t          rsp;
	logic [1:0]        adc_st, sw, taken, clr, sw_st, r_cmd, relay, led;
	logic [1:0][11:0]  adc;
	logic [1:0][15:0]  cnt;
	switch_cfg_t [1:0] sw_cfg;
	relay_cfg_t [1:0]  r_cfg;
	logic [4:0]        dip;
	logic [7:0]        offs, baddr;
	logic [11:0]       d0;
	logic [24:0]       e;
	logic [24:0]       exp_q[$];
	int                n_mismatch, comparisons;

	modbus_master_model i_mst (.clk_i(clk_i), .req_o(req));
	io_module_core #(.ADC_CYCLES(40), .SAMPLE_CYCLES(8), .MS_CYCLES(10))
	i_dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .rsp_o(rsp),
		.adc_start_o(adc_st), .adc_data_i(adc),
		.switch_sense_input_i(sw), .switch_cfg_i(sw_cfg),
		.count_clear_i(clr), .count_taken_i(taken),
		.event_count_o(cnt), .switch_state_o(sw_st),
		.relay_cfg_i(r_cfg), .relay_cmd_i(r_cmd), .relay_o(relay),
		.relay_led_o(led), .dip_addr_i(dip), .addr_offset_i(offs),
		.bus_addr_o(baddr), .bus_addr_valid_o(bvalid));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		comparisons++;
		if (got !== want) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	function automatic logic [24:0] ok(input logic [15:0] d);
		return {9'h000, d};
	endfunction
	function automatic logic [24:0] ex(input logic [7:0] c);
		return {1'b1, c, 16'h0000};
	endfunction
	// Expected answer is queued before the request leaves
	task automatic bus(input logic [7:0] f, input logic [15:0] a,
		input logic [15:0] d, input logic [24:0] x);
		exp_q.push_back(x);
		i_mst.xfer(f, a, d);
	endtask
	// Refusals compare the code only, though the core then returns zero read data
	always @(negedge clk_i) begin
		if (rsp.valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk(32'h1, 32'h0);
			else begin
				e = exp_q.pop_front();
				if (e[24])
					chk({rsp.exc, rsp.exc_code}, e[24:16]);
				else
					chk({rsp.exc, rsp.rdata}, {e[24], e[15:0]});
			end
		end
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic do_reset;
		rstn_i = 1'b0;
		wait_n(8);
		rstn_i = 1'b1;
		wait_n(4);
	endtask
	// Both switches high then low, long enough to pass the debounce;
	// relay 1 follows switch 0 throughout
	task automatic pulse_sw;
		sw = 2'b11;
		wait_n(80);
		chk(relay[1], 1);
		chk(sw_st, 2'b11);
		sw = 2'b00;
		wait_n(80);
		chk(relay[1], 0);
		chk(sw_st, 2'b00);
	endtask
	task automatic report_and_stop;
		$display("n_mismatch %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		wait_n(20000);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'hb2d82f52));
		rstn_i = 1'b0;
		adc = '0;
		sw = 2'b00;
		taken = 2'b00;
		clr = 2'b00;
		r_cmd = 2'b00;
		sw_cfg[0] = '{TRIG_RISE, 1'b0, 5'h04};
		sw_cfg[1] = '{TRIG_LEVEL, 1'b0, 5'h02};
		r_cfg[0] = '{RELAY_PULSE, 16'h0005, 4'h0};
		r_cfg[1] = '{RELAY_FOLLOW, 16'h0032, 4'h0};
		dip = 5'h1f;
		offs = 8'h01;
		do_reset();
		chk(baddr, 8'h20);
		chk(bvalid, 1);
		bus(FC_READ_HOLD, REG_FILTER, 16'h0, ok(16'h0006));
		bus(FC_READ_HOLD, REG_RANGE, 16'h0, ok(16'h0000));
		bus(FC_WRITE_MULTI, REG_FILTER, 16'h0063, ok(16'h0063));
		bus(FC_READ_HOLD, REG_FILTER, 16'h0, ok(16'h0010));
		bus(FC_WRITE_ONE, REG_FILTER, 16'h0, ok(16'h0000));
		bus(FC_READ_HOLD, REG_FILTER, 16'h0, ok(16'h0001));
		bus(8'h05, REG_FILTER, 16'h0, ex(EXC_BAD_FUNC));
		bus(FC_READ_HOLD, 16'h1234, 16'h0, ex(EXC_BAD_ADDR));
		bus(FC_WRITE_ONE, REG_RAW_BASE, 16'h5, ex(EXC_BAD_ADDR));
		d0 = 12'($urandom);
		adc[0] = d0;
		adc[1] = 12'h800;
		wait_n(130);
		bus(FC_READ_INPUT, REG_RAW_BASE, 16'h0, ok(16'(d0)));
		bus(FC_READ_INPUT, REG_ENG_BASE, 16'h0,
			ok(16'(32'(d0) * 25000 / 4095)));
		bus(FC_READ_INPUT, 16'h0001, 16'h0, ok(16'h0800));
		bus(FC_WRITE_ONE, 16'h0191, 16'h0800, ok(16'h0800));
		bus(FC_READ_HOLD, 16'h0191, 16'h0, ok(16'h0800));
		bus(FC_WRITE_ONE, 16'h0259, 16'h0, ok(16'h0000));
		wait_n(50);
		bus(FC_READ_INPUT, 16'h0065, 16'h0, ok(16'd20000));
		bus(FC_WRITE_ONE, REG_RANGE, 16'h0002, ok(16'h0002));
		bus(FC_READ_HOLD, REG_RANGE, 16'h0, ok(16'h0001));
		adc[0] = 12'd160;
		wait_n(130);
		bus(FC_READ_INPUT, REG_ENG_BASE, 16'h0, ok(16'h0000));
		adc[0] = 12'hfff;
		wait_n(130);
		bus(FC_READ_INPUT, REG_ENG_BASE, 16'h0, ok(16'd25000));
		// A glitch shorter than the debounce must not count
		sw[0] = 1'b1;
		wait_n(16);
		sw[0] = 1'b0;
		wait_n(80);
		chk(cnt[0], 0);
		repeat (3) pulse_sw();
		chk(cnt[0], 3);
		chk(cnt[1], 6);
		taken = 2'b01;
		wait_n(1);
		taken = 2'b00;
		wait_n(2);
		chk(cnt[0], 0);
		sw_cfg[0].mode = TRIG_FALL;
		sw_cfg[0].manual_clr = 1'b1;
		pulse_sw();
		taken = 2'b01;
		wait_n(1);
		taken = 2'b00;
		wait_n(2);
		chk(cnt[0], 1);
		// Manual mode: only the explicit clear empties the counter
		clr = 2'b01;
		wait_n(1);
		clr = 2'b00;
		wait_n(2);
		chk(cnt[0], 0);
		r_cmd[0] = 1'b1;
		wait_n(1);
		chk(relay[0], 1);
		wait_n(480);
		chk(relay[0], 1);
		wait_n(40);
		chk(relay[0], 0);
		r_cmd[0] = 1'b0;
		r_cfg[0].mode = RELAY_LEVEL;
		wait_n(1);
		r_cmd[0] = 1'b1;
		wait_n(600);
		chk(relay[0], 1);
		chk(led[0], 1);
		r_cmd[0] = 1'b0;
		wait_n(2);
		chk({relay[0], led[0]}, 0);
		// Position 1 on alone is the top bit of the switch value
		dip = 5'h01;
		offs = 8'h03;
		do_reset();
		chk(baddr, 8'h13);
		// The second reset must bring the filter depth back to its default
		bus(FC_READ_HOLD, REG_FILTER, 16'h0, ok(16'h0006));
		dip = 5'h00;
		offs = 8'h64;
		wait_n(10);
		chk(baddr, 8'h13);
		chk(exp_q.size(), 0);
		report_and_stop();
	end
endmodule // tb_io_module_core
